// >>> src/utx_channel.sv
// utx_channel: even-channel asynchronous transmitter with register slave and interrupts
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - reading data register clears buffer-full flag
// - status shows errors; clear-trigger ones clear them
// - frame: start, data, parity, stop at baud
// - even channel transmits only, odd receives
// - data length selectable seven or eight bits
// - direction zero msb first, one lsb
// - output selectable normal or inverted level
// - parity none, zero, even or odd
// - stop field selects one or two
// - interrupt source: transfer end or buffer empty
// - clock select picks prescaler output a or b
// - divider field at least two, max 127
// - receive errors set flags and error interrupt
// - transmit appends parity and stop bits
// - receive pin routable to interrupt or timer
// - writing low data starts transmission when idle
// - write while buffer full overwrites pending word
// - op clock from prescaler setting and select bit
module utx_channel (
   input  wire logic                  CLOCK,         // system clock, 100 MHz
   input  wire logic                  RST_B,         // asynchronous reset, active low
   input  wire utx_pkg::utx_bus_req_t BUS_REQ,       // register bus request
   output logic [15:0]                BUS_RDATA,     // read data, cycle after read strobe
   input  wire utx_pkg::utx_rx_err_t  RX_ERR,        // one-cycle error pulses from receiver
   input  wire logic                  SERIAL_RX_PIN, // receive line from remote device
   output logic                       SERIAL_TX_PIN, // transmit line to remote device
   output logic                       EXT_IRQ_IN,    // rx pin routed to external interrupt
   output logic                       TIMER_IN,      // rx pin routed to timer input
   output logic                       IRQ            // level interrupt output
);
   import utx_pkg::*;

   // ==================== state ====================
   typedef struct packed {
      logic [15:0]          mode;      // channel_mode
      logic [15:0]          comm;      // channel_comm_setting
      logic [15:0]          data;      // low_data_buffer and baud_divider_upper
      logic [7:0]           prescale;  // clock_prescale_select
      logic [3:0]           ctrl;      // enable, level, input switch
      logic                 bff;       // buffer_full_flag
      logic [2:0]           err;       // framing, parity, overrun flags
      logic [UTX_IRQ_W-1:0] irq_st;    // sticky interrupt status
      logic [UTX_IRQ_W-1:0] irq_en;    // interrupt enable
      logic [15:0]          rdata;     // registered read data
      logic [15:0]          pre_cnt;   // free prescaler counter
      logic [7:0]           baud_cnt;  // half-bit divider counter
      logic                 half;      // second half of a bit period
      utx_state_t           state;     // transmitter state
      logic [7:0]           shift;     // word being sent
      logic [2:0]           bit_idx;   // data bits sent so far
      logic                 par;       // running parity
      logic                 stop2;     // second stop bit pending
      logic                 line;      // unencoded line level
   } utx_st_t;

   utx_st_t st_r;  // registered state
   utx_st_t st_nxt; // next state

   // ==================== combinational helpers ====================
   logic       ck_a;      // prescaler output a tick
   logic       ck_b;      // prescaler output b tick
   logic       mck_tick;  // operation clock enable
   logic       baud_tick; // half-bit period elapsed
   logic [6:0] div;       // divider field
   logic [2:0] last_idx;  // index of last data bit
   logic       nbit;      // next data bit to send
   logic       wr_data;   // software write to data register
   logic       busy;      // frame in flight
   logic       tx_evt;    // transmit interrupt event this cycle

   always_comb begin
      // prescaler taps: a tick when the low bits of the counter all wrap
      ck_a = (st_r.pre_cnt & ((16'h0001 << st_r.prescale[3:0]) - 16'h0001)) == 16'h0000;
      ck_b = (st_r.pre_cnt & ((16'h0001 << st_r.prescale[7:4]) - 16'h0001)) == 16'h0000;
      mck_tick = st_r.mode[UTX_MODE_CKS] ? ck_b : ck_a;
      // divider below the legal floor is clamped, so the rate never exceeds mck/6
      div = (st_r.data[15:9] < UTX_DIV_MIN) ? UTX_DIV_MIN : st_r.data[15:9];
      baud_tick = mck_tick && (st_r.baud_cnt == {1'b0, div});
      last_idx = st_r.comm[UTX_COMM_DLS] ? 3'h7 : 3'h6;
      // bit order: lsb first shifts right, msb first picks top of the used width
      if (st_r.comm[UTX_COMM_DIR]) begin
         nbit = st_r.shift[0];
      end else begin
         nbit = st_r.comm[UTX_COMM_DLS] ? st_r.shift[7] : st_r.shift[6];
      end
      wr_data = BUS_REQ.wr && (BUS_REQ.addr == UTX_OFS_DATA);
      busy = (st_r.state != UTX_IDLE);
   end

   // ==================== next-state logic ====================
   always_comb begin
      st_nxt = st_r;
      tx_evt = 1'b0;
      st_nxt.pre_cnt = st_r.pre_cnt + 16'h0001;

      // ---- baud divider: two half periods of (div+1) mck ticks each ----
      if (busy && mck_tick) begin
         st_nxt.baud_cnt = baud_tick ? 8'h00 : st_r.baud_cnt + 8'h01;
      end else if (!busy) begin
         st_nxt.baud_cnt = 8'h00;
      end
      if (busy && baud_tick) begin
         st_nxt.half = !st_r.half;
      end

      // ---- transmitter sequence; only the even channel has one ----
      unique case (st_r.state)
         UTX_IDLE: begin
            st_nxt.line = 1'b1;
            st_nxt.half = 1'b0;
            // start as soon as a word is buffered and the channel runs
            if (st_r.bff && st_r.ctrl[UTX_CTRL_EN] && st_r.comm[UTX_COMM_TXE]) begin
               st_nxt.state = UTX_START;
               st_nxt.shift = st_r.data[7:0];
               st_nxt.bff = 1'b0;
               st_nxt.line = 1'b0;
               st_nxt.bit_idx = 3'h0;
               st_nxt.par = 1'b0;
               // buffer freed: buffer-empty interrupt in continuous mode
               if (st_r.mode[UTX_MODE_MD0]) begin
                  tx_evt = 1'b1;
               end
            end
         end
         UTX_START: begin
            if (baud_tick && st_r.half) begin
               st_nxt.state = UTX_DATA;
               st_nxt.line = nbit;
            end
         end
         UTX_DATA: begin
            if (baud_tick && st_r.half) begin
               st_nxt.par = st_r.par ^ st_r.line;
               st_nxt.shift = st_r.comm[UTX_COMM_DIR] ? {1'b0, st_r.shift[7:1]} : {st_r.shift[6:0], 1'b0};
               st_nxt.bit_idx = st_r.bit_idx + 3'h1;
               if (st_r.bit_idx == last_idx) begin
                  st_nxt.stop2 = (st_r.comm[UTX_COMM_SLC+1 -: 2] == UTX_STOP_TWO);
                  if (st_r.comm[UTX_COMM_PTC+1 -: 2] == UTX_PAR_NONE) begin
                     st_nxt.state = UTX_STOP;
                     st_nxt.line = 1'b1;
                  end else begin
                     st_nxt.state = UTX_PARITY;
                  end
               end else begin
                  st_nxt.line = st_r.comm[UTX_COMM_DIR] ? st_r.shift[1]
                              : (st_r.comm[UTX_COMM_DLS] ? st_r.shift[6] : st_r.shift[5]);
               end
               // parity value for the slot that follows the last bit
               if (st_r.bit_idx == last_idx) begin
                  unique case (st_r.comm[UTX_COMM_PTC+1 -: 2])
                     UTX_PAR_NONE: ;
                     UTX_PAR_ZERO: st_nxt.line = 1'b0;
                     UTX_PAR_EVEN: st_nxt.line = st_r.par ^ st_r.line;
                     default:      st_nxt.line = ~(st_r.par ^ st_r.line);
                  endcase
               end
            end
         end
         UTX_PARITY: begin
            if (baud_tick && st_r.half) begin
               st_nxt.state = UTX_STOP;
               st_nxt.line = 1'b1;
            end
         end
         UTX_STOP: begin
            if (baud_tick && st_r.half) begin
               if (st_r.stop2) begin
                  st_nxt.stop2 = 1'b0;
               end else begin
                  st_nxt.state = UTX_IDLE;
                  // transfer-end interrupt in single-transfer mode
                  if (!st_r.mode[UTX_MODE_MD0]) begin
                     tx_evt = 1'b1;
                  end
               end
            end
         end
         default: st_nxt.state = UTX_IDLE;
      endcase

      // ---- register writes ----
      if (BUS_REQ.wr) begin
         unique case (BUS_REQ.addr)
            UTX_OFS_MODE:   st_nxt.mode = BUS_REQ.wdata;
            UTX_OFS_COMM:   st_nxt.comm = BUS_REQ.wdata;
            UTX_OFS_DATA:   st_nxt.data = BUS_REQ.wdata;
            UTX_OFS_PRESCL: st_nxt.prescale = BUS_REQ.wdata[7:0];
            UTX_OFS_CTRL:   st_nxt.ctrl = BUS_REQ.wdata[3:0];
            UTX_OFS_CLEAR:  st_nxt.err = st_r.err & ~BUS_REQ.wdata[2:0];
            UTX_OFS_IRQ_CLR: st_nxt.irq_st = st_r.irq_st & ~BUS_REQ.wdata[UTX_IRQ_W-1:0];
            UTX_OFS_IRQ_EN: st_nxt.irq_en = BUS_REQ.wdata[UTX_IRQ_W-1:0];
            default: ;
         endcase
      end
      // a new word always lands in the buffer, replacing any pending one
      if (wr_data) begin
         st_nxt.bff = 1'b1;
      end
      // transmit event applied after the clear, so a same-cycle set wins
      if (tx_evt) begin
         st_nxt.irq_st[UTX_IRQ_TX] = 1'b1;
      end

      // ---- register reads; data read frees the buffer ----
      if (BUS_REQ.rd) begin
         unique case (BUS_REQ.addr)
            UTX_OFS_MODE:   st_nxt.rdata = st_r.mode;
            UTX_OFS_COMM:   st_nxt.rdata = st_r.comm;
            UTX_OFS_DATA: begin
               st_nxt.rdata = st_r.data;
               st_nxt.bff = 1'b0;
            end
            UTX_OFS_STATUS: st_nxt.rdata = {9'h000, busy, st_r.bff, 2'h0, st_r.err};
            UTX_OFS_PRESCL: st_nxt.rdata = {8'h00, st_r.prescale};
            UTX_OFS_CTRL:   st_nxt.rdata = {12'h000, st_r.ctrl};
            UTX_OFS_IRQ_ST: st_nxt.rdata = {14'h0000, st_r.irq_st};
            UTX_OFS_IRQ_EN: st_nxt.rdata = {14'h0000, st_r.irq_en};
            default:        st_nxt.rdata = 16'h0000; // unmapped and write-only read zero
         endcase
      end else begin
         st_nxt.rdata = 16'h0000;
      end

      // ---- error events win over a same-cycle clear ----
      if (st_r.comm[UTX_COMM_RXE]) begin
         if (RX_ERR.overrun) st_nxt.err[UTX_ST_OVF] = 1'b1;
         if (RX_ERR.parity)  st_nxt.err[UTX_ST_PEF] = 1'b1;
         if (RX_ERR.framing) st_nxt.err[UTX_ST_FEF] = 1'b1;
         if (RX_ERR.overrun || RX_ERR.parity || RX_ERR.framing) begin
            st_nxt.irq_st[UTX_IRQ_ERR] = 1'b1;
         end
      end
   end

   // ==================== state register ====================
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= '{mode: UTX_MODE_RST, comm: UTX_COMM_RST, data: UTX_DATA_RST,
                   line: 1'b1, state: UTX_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==================== outputs ====================
   always_comb begin
      // inverted mode flips the whole frame, idle included
      SERIAL_TX_PIN = st_r.line ^ st_r.ctrl[UTX_CTRL_SOL] ^ st_r.comm[UTX_COMM_DAP];
      BUS_RDATA = st_r.rdata;
      IRQ = |(st_r.irq_st & st_r.irq_en);
      // gated copies so an unused route stays quiet
      EXT_IRQ_IN = SERIAL_RX_PIN & st_r.ctrl[UTX_CTRL_ISC];
      TIMER_IN = SERIAL_RX_PIN & st_r.ctrl[UTX_CTRL_ISC+1];
   end
endmodule : utx_channel
`default_nettype wire

// >>> src/utx_pkg.sv
// utx_pkg: register map, field positions and shared types of the uart transmit channel
package utx_pkg;
   // ==================== register byte addresses ====================
   localparam logic [7:0] UTX_OFS_MODE    = 8'h00; // channel_mode
   localparam logic [7:0] UTX_OFS_COMM    = 8'h04; // channel_comm_setting
   localparam logic [7:0] UTX_OFS_DATA    = 8'h08; // channel_data_and_divider
   localparam logic [7:0] UTX_OFS_STATUS  = 8'h0c; // channel_status_reg (ro)
   localparam logic [7:0] UTX_OFS_CLEAR   = 8'h10; // flag_clear_trigger (wo)
   localparam logic [7:0] UTX_OFS_PRESCL  = 8'h14; // clock_prescale_select
   localparam logic [7:0] UTX_OFS_CTRL    = 8'h18; // enable, output level, input switch
   localparam logic [7:0] UTX_OFS_IRQ_ST  = 8'h1c; // sticky interrupt status (ro)
   localparam logic [7:0] UTX_OFS_IRQ_CLR = 8'h20; // interrupt clear (wo)
   localparam logic [7:0] UTX_OFS_IRQ_EN  = 8'h24; // interrupt enable
   // ==================== mode register fields ====================
   localparam int UTX_MODE_CKS = 15; // op_clock_select
   localparam int UTX_MODE_MD0 = 0;  // interrupt_source_select
   // ==================== comm setting fields ====================
   localparam int UTX_COMM_TXE   = 15; // transmit_enable_bit
   localparam int UTX_COMM_RXE   = 14; // receive_enable_bit
   localparam int UTX_COMM_DAP   = 13; // data_phase_select
   localparam int UTX_COMM_PTC   = 8;  // parity_type lo position (2 bits)
   localparam int UTX_COMM_DIR   = 7;  // bit_order_select
   localparam int UTX_COMM_SLC   = 4;  // stop_length lo position (2 bits)
   localparam int UTX_COMM_DLS   = 0;  // data_length_select: 0 = 7 bits, 1 = 8 bits
   // ==================== status / clear fields ====================
   localparam int UTX_ST_OVF = 0; // overrun error
   localparam int UTX_ST_PEF = 1; // parity error
   localparam int UTX_ST_FEF = 2; // framing error
   localparam int UTX_ST_BFF = 5; // buffer_full_flag
   localparam int UTX_ST_TSF = 6; // transfer busy
   // ==================== control fields ====================
   localparam int UTX_CTRL_EN  = 0; // channel operation enable
   localparam int UTX_CTRL_SOL = 1; // output_level_select: 1 = inverted
   localparam int UTX_CTRL_ISC = 2; // input_switch_control (2 bits)
   // ==================== interrupt event bits ====================
   localparam int UTX_IRQ_TX  = 0; // tx_interrupt event
   localparam int UTX_IRQ_ERR = 1; // receive error event
   localparam int UTX_IRQ_W   = 2;
   // ==================== reset values and limits ====================
   localparam logic [15:0] UTX_MODE_RST = 16'h0020;
   localparam logic [15:0] UTX_COMM_RST = 16'h0087;
   localparam logic [15:0] UTX_DATA_RST = 16'h0000;
   localparam logic [6:0]  UTX_DIV_MIN  = 7'h02; // smallest legal divider field
   localparam logic [1:0]  UTX_PAR_NONE = 2'h0;
   localparam logic [1:0]  UTX_PAR_ZERO = 2'h1;
   localparam logic [1:0]  UTX_PAR_EVEN = 2'h2;
   localparam logic [1:0]  UTX_STOP_TWO = 2'h2;

   // transmitter sequencing states
   typedef enum logic [2:0] {
      UTX_IDLE   = 3'b000,
      UTX_START  = 3'b001,
      UTX_DATA   = 3'b010,
      UTX_PARITY = 3'b011,
      UTX_STOP   = 3'b100
   } utx_state_t;

   // register bus request carried as one bundle
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } utx_bus_req_t;

   // receive-side error reports from the partner odd channel
   typedef struct packed {
      logic overrun;
      logic parity;
      logic framing;
   } utx_rx_err_t;
endpackage : utx_pkg

// >>> verif/utx_channel_sva.sv
// utx_channel_sva: port-level checks of the uart transmit channel
`timescale 1ns/1ps
`default_nettype none
module utx_channel_sva (
   input wire logic                  CLOCK,
   input wire logic                  RST_B,
   input wire utx_pkg::utx_bus_req_t BUS_REQ,
   input wire logic [15:0]           BUS_RDATA,
   input wire utx_pkg::utx_rx_err_t  RX_ERR,
   input wire logic                  SERIAL_RX_PIN,
   input wire logic                  SERIAL_TX_PIN,
   input wire logic                  EXT_IRQ_IN,
   input wire logic                  TIMER_IN,
   input wire logic                  IRQ
);
   import utx_pkg::*;
   logic [15:0] ctrl_r; // shadow of control
   logic [15:0] comm_r; // shadow of comm setting
   logic [1:0]  ien_r;  // shadow of interrupt enable
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // ==================== shadows ====================
   // follows bus writes, since the checker cannot see the block's registers
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_r <= 16'h0000;
         comm_r <= UTX_COMM_RST;
         ien_r  <= 2'h0;
      end else if (BUS_REQ.wr) begin
         if (BUS_REQ.addr == UTX_OFS_CTRL) ctrl_r <= BUS_REQ.wdata;
         if (BUS_REQ.addr == UTX_OFS_COMM) comm_r <= BUS_REQ.wdata;
         if (BUS_REQ.addr == UTX_OFS_IRQ_EN) ien_r <= BUS_REQ.wdata[1:0];
      end
   end
   // ==================== properties ====================
   property p_ext_route; EXT_IRQ_IN == (SERIAL_RX_PIN & ctrl_r[UTX_CTRL_ISC]); endproperty
   a_ext_route: assert property (p_ext_route) else $error("ext irq route wrong");
   property p_timer_route; TIMER_IN == (SERIAL_RX_PIN & ctrl_r[UTX_CTRL_ISC + 1]); endproperty
   a_timer_route: assert property (p_timer_route) else $error("timer route wrong");
   property p_rdata_idle; !$past(BUS_REQ.rd) |-> BUS_RDATA == 16'h0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   property p_unmapped; BUS_REQ.rd && BUS_REQ.addr > UTX_OFS_IRQ_EN |=> BUS_RDATA == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // a data read followed at once by a status read must show the buffer empty
   property p_bff_clear; $past(BUS_REQ.rd && BUS_REQ.addr == UTX_OFS_DATA) && BUS_REQ.rd
      && BUS_REQ.addr == UTX_OFS_STATUS |=> !BUS_RDATA[UTX_ST_BFF]; endproperty
   a_bff_clear: assert property (p_bff_clear) else $error("buffer full survives data read");
   property p_err_clear; (BUS_REQ.wr && BUS_REQ.addr == UTX_OFS_CLEAR && RX_ERR == 3'h0) ##1 (BUS_REQ.rd
      && BUS_REQ.addr == UTX_OFS_STATUS) |=> (BUS_RDATA[2:0] & $past(BUS_REQ.wdata[2:0], 2)) == 3'h0; endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");
   property p_err_irq; (|RX_ERR) && comm_r[UTX_COMM_RXE] && ien_r[UTX_IRQ_ERR] |-> ##[1:2] IRQ; endproperty
   a_err_irq: assert property (p_err_irq) else $error("error interrupt missing");
   // shortest bit is six cycles; a level change made by a register write is excused
   property p_bit_min; $changed(SERIAL_TX_PIN) && !$past(BUS_REQ.wr) && !$past(BUS_REQ.wr, 2)
      |=> $stable(SERIAL_TX_PIN) [*5]; endproperty
   a_bit_min: assert property (p_bit_min) else $error("line bit shorter than six cycles");
   property p_irq_mask; ien_r == 2'h0 |-> !IRQ; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all sources masked");
endmodule : utx_channel_sva
bind utx_channel utx_channel_sva chk_u (.CLOCK(CLOCK), .RST_B(RST_B), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
   .RX_ERR(RX_ERR), .SERIAL_RX_PIN(SERIAL_RX_PIN), .SERIAL_TX_PIN(SERIAL_TX_PIN), .EXT_IRQ_IN(EXT_IRQ_IN),
   .TIMER_IN(TIMER_IN), .IRQ(IRQ));
`default_nettype wire

// >>> verif/utx_channel_tb.sv
// utx_channel_tb: register-level tests of the uart transmit channel
`timescale 1ns/1ps
`default_nettype none
module utx_channel_tb;
   import utx_pkg::*;
   logic clock = 1'b0, rst_b = 1'b0, rx_level = 1'b1, v_q = 1'b0;
   logic rx_line, tx_line, ext_irq, timer_in, irq, irq_sel;
   utx_bus_req_t bus_req = '0;
   utx_rx_err_t rx_err = '0;
   logic [15:0] bus_rdata, frame, fx, rexp = '0, rmask = '0, e_q, m_q;
   logic [7:0] bit_len = 8'h06, frames, base;
   logic [3:0] nbits = 4'h0, pins;
   string rname, n_q;
   int fail_count = 0, total_checks = 0, cycles = 0, i, nx;
   // frame table: data length, lsb first, parity, two stops, word
   logic [12:0] cases [4] = '{13'h18a5, 13'h034b, 13'h1437, 13'h0f6c};
   assign pins = {timer_in, ext_irq, tx_line, irq};
   utx_channel dut_u (.CLOCK(clock), .RST_B(rst_b), .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata), .RX_ERR(rx_err),
      .SERIAL_RX_PIN(rx_line), .SERIAL_TX_PIN(tx_line), .EXT_IRQ_IN(ext_irq), .TIMER_IN(timer_in), .IRQ(irq));
   utx_remote_rx far_u (.clk(clock), .tx_line(tx_line), .rx_level(rx_level), .bit_len(bit_len),
      .nbits(nbits), .rx_line(rx_line), .frame(frame), .frames(frames));
   always #5 clock = ~clock;
   // ==================== checks ====================
   task conclude();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // hang guard, several times the expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   // read data stands only in the cycle after the strobe, so it is judged mid-cycle
   always @(posedge clock) begin
      v_q <= bus_req.rd;
      e_q <= rexp;
      m_q <= rmask;
      n_q <= rname;
   end
   always @(negedge clock) if (v_q) chk(n_q, e_q, bus_rdata & m_q);
   // ==================== bus tasks ====================
   // each task leaves its request up for exactly one edge; the next call replaces it
   task wr(logic [7:0] a, logic [15:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
   endtask : wr
   task rdc(string n, logic [7:0] a, logic [15:0] e, logic [15:0] m);
      rexp <= e;
      rmask <= m;
      rname <= n;
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
   endtask : rdc
   task idle(int n);
      bus_req <= '0;
      repeat (n) @(posedge clock);
   endtask : idle
   task pin(string n, logic e, int k);
      bus_req <= '0;
      @(negedge clock);
      chk(n, {15'h0000, e}, {15'h0000, pins[k]});
      @(posedge clock);
   endtask : pin
   task wait_frames(logic [7:0] t);
      bus_req <= '0;
      for (int k = 0; k < 3000 && frames !== t; k++) @(posedge clock);
      chk("frames", {8'h00, t}, {8'h00, frames});
   endtask : wait_frames
   // ==================== frame model ====================
   function automatic logic [15:0] efr(logic [12:0] c, output int n);
      logic [15:0] f;
      int nd;
      logic p;
      nd = c[12] ? 8 : 7;
      f = 16'h0000;
      p = 1'b0;
      n = 1;
      for (int j = 0; j < nd; j++) begin
         f[n] = c[11] ? c[j] : c[nd - 1 - j];
         p ^= f[n];
         n++;
      end
      if (c[10:9] != 2'h0) n++;
      f[n - 1] = (c[10:9] == 2'h2) ? p : (c[10:9] == 2'h3) ? ~p : f[n - 1];
      f[n] = 1'b1;
      f[n + 1] = c[8];
      n = n + 1 + c[8];
      return f;
   endfunction : efr
   function automatic logic [15:0] cfg(logic [12:0] c);
      return {1'b1, 5'h00, c[10:9], c[11], 1'b0, c[8] ? 2'h2 : 2'h1, 3'h0, c[12]};
   endfunction : cfg
   task send(logic [12:0] c, logic [6:0] dv);
      fx = efr(c, nx);
      nbits = nx[3:0];
      base = frames;
      wr(UTX_OFS_COMM, cfg(c));
      idle(8);
      wr(UTX_OFS_DATA, {dv, 1'b0, c[7:0]});
      wait_frames(base + 8'h01);
      chk("frame", fx, frame);
      idle(12);
   endtask : send
   // ==================== scenarios ====================
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rdc("mode", UTX_OFS_MODE, UTX_MODE_RST, 16'hffff);
      rdc("comm", UTX_OFS_COMM, UTX_COMM_RST, 16'hffff);
      rdc("data", UTX_OFS_DATA, UTX_DATA_RST, 16'hffff);
      rdc("unmapped", 8'h30, 16'h0000, 16'hffff);
      pin("tx idle", 1'b1, 1);
      wr(UTX_OFS_CTRL, 16'h0001);
      wr(UTX_OFS_IRQ_EN, 16'h0001);
      for (i = 0; i < 4; i++) send(cases[i], i == 3 ? 7'h00 : 7'h02);
      pin("irq end", 1'b1, 0);
      rdc("irq st", UTX_OFS_IRQ_ST, 16'h0001, 16'h0001);
      wr(UTX_OFS_IRQ_CLR, 16'h0001);
      pin("irq cleared", 1'b0, 0);
      // buffer-empty interrupt, overwrite of the pending word, and a dropped word
      wr(UTX_OFS_MODE, 16'h0001);
      wr(UTX_OFS_COMM, cfg(13'h1833));
      fx = efr(13'h1833, nx);
      nbits = nx[3:0];
      base = frames;
      wr(UTX_OFS_DATA, 16'h0411);
      idle(4);
      pin("irq empty", 1'b1, 0);
      rdc("busy", UTX_OFS_STATUS, 16'h0040, 16'h0060);
      wr(UTX_OFS_DATA, 16'h0422);
      wr(UTX_OFS_DATA, 16'h0433);
      rdc("bff set", UTX_OFS_STATUS, 16'h0020, 16'h0020);
      wait_frames(base + 8'h01);
      idle(12);
      wr(UTX_OFS_DATA, 16'h0444);
      rdc("data rd", UTX_OFS_DATA, 16'h0444, 16'hffff);
      rdc("bff clr", UTX_OFS_STATUS, 16'h0000, 16'h0020);
      wait_frames(base + 8'h02);
      chk("frame", fx, frame);
      idle(150);
      wait_frames(base + 8'h02);
      // inverted level, then the second prescaler output
      wr(UTX_OFS_CTRL, 16'h0003);
      pin("tx inv idle", 1'b0, 1);
      wr(UTX_OFS_CTRL, 16'h0001);
      wr(UTX_OFS_MODE, 16'h8000);
      wr(UTX_OFS_PRESCL, 16'h0010);
      idle(150);
      bit_len = 8'h0c;
      send(cases[0], 7'h02);
      // receive errors: flags, interrupt and selective clearing
      wr(UTX_OFS_COMM, 16'h4000);
      wr(UTX_OFS_IRQ_EN, 16'h0002);
      for (i = 0; i < 3; i++) begin
         rx_err <= utx_rx_err_t'(3'h1 << i);
         idle(1);
         rx_err <= '0;
         idle(1);
      end
      rdc("err flags", UTX_OFS_STATUS, 16'h0007, 16'h0007);
      pin("irq err", 1'b1, 0);
      wr(UTX_OFS_CLEAR, 16'h0002);
      rdc("err part", UTX_OFS_STATUS, 16'h0005, 16'h0007);
      wr(UTX_OFS_CLEAR, 16'h0005);
      rdc("err none", UTX_OFS_STATUS, 16'h0000, 16'h0007);
      wr(UTX_OFS_IRQ_CLR, 16'h0002);
      pin("irq err clr", 1'b0, 0);
      // receive pin routing
      wr(UTX_OFS_CTRL, 16'h0005);
      rx_level <= 1'b0;
      pin("ext low", 1'b0, 2);
      rx_level <= 1'b1;
      pin("ext high", 1'b1, 2);
      pin("timer off", 1'b0, 3);
      wr(UTX_OFS_CTRL, 16'h0009);
      pin("timer on", 1'b1, 3);
      idle(2);
      conclude();
   end
endmodule : utx_channel_tb
`default_nettype wire

// >>> verif/utx_remote_rx.sv
// utx_remote_rx: remote serial device decoding frames from the transmit line
`timescale 1ns/1ps
`default_nettype none
module utx_remote_rx (
   input  wire logic       clk,      // sampling clock
   input  wire logic       tx_line,  // line from the channel
   input  wire logic       rx_level, // level put on the line back
   input  wire logic [7:0] bit_len,  // bit period in clock cycles
   input  wire logic [3:0] nbits,    // bits per frame, start and stop included
   output logic            rx_line,  // line back to the channel
   output var logic [15:0] frame,    // bits in wire order, first at bit 0
   output var logic [7:0]  frames    // frames decoded so far
);
   int i; // bit index
   assign rx_line = rx_level;
   // ==================== decoder ====================
   // samples mid-bit; no wait after the last bit so back-to-back starts are caught
   initial begin
      frames = 8'h00;
      frame = 16'h0000;
      forever begin
         @(negedge tx_line);
         frame = 16'h0000;
         repeat (bit_len / 2) @(posedge clk);
         for (i = 0; i < int'(nbits); i++) begin
            frame[i] = tx_line;
            if (i < int'(nbits) - 1) repeat (bit_len) @(posedge clk);
         end
         frames = frames + 8'h01;
      end
   end
endmodule : utx_remote_rx
`default_nettype wire
